//--- qeo_pkg.sv
// shared constants, types and helper functions of the quadrature output stage
package qeo_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int GAP_W = 10;
  localparam int GAP_0_NS = 120;
  localparam int GAP_1_NS = 290;
  localparam int GAP_2_NS = 480;
  localparam int GAP_3_NS = 1000;
  localparam int GAP_4_NS = 2000;
  localparam int GAP_5_NS = 4000;
  localparam int GAP_6_NS = 8000;
  localparam int GAP_7_NS = 16000;
  localparam int GAP_8_NS = 24000;

  // ----------------------------------------------------------------
  // resolution (fine step from the field interpolator is 5 um)
  // ----------------------------------------------------------------
  localparam int FINE_UM = 5;
  localparam int RES_0_UM = 5;
  localparam int RES_1_UM = 10;
  localparam int RES_2_UM = 25;
  localparam int RES_3_UM = 50;
  localparam int POLE_PITCH_UM = 5000;
  localparam int RATIO_W = 4;
  localparam int BACKLOG_W = 8;

  // quadrature levels {lead, lag}
  localparam logic [1:0] QUAD_RESET = 2'h0;
  localparam logic [1:0] QUAD_INDEX = 2'h3;

  typedef struct packed {
    logic ref_opt;      // reference output fitted
    logic diff_mode;    // 1: complementary pairs, 0: supply-level single ended
    logic [1:0] res_sel;
    logic [3:0] gap_sel;
  } qeo_cfg_t;

  // least time rounds up to whole cycles
  function automatic logic [GAP_W-1:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return GAP_W'(c);
  endfunction

  function automatic logic [GAP_W-1:0] gap_cycles(input logic [3:0] sel);
    case (sel)
      4'h0: return ns_to_cyc(GAP_0_NS);
      4'h1: return ns_to_cyc(GAP_1_NS);
      4'h2: return ns_to_cyc(GAP_2_NS);
      4'h3: return ns_to_cyc(GAP_3_NS);
      4'h4: return ns_to_cyc(GAP_4_NS);
      4'h5: return ns_to_cyc(GAP_5_NS);
      4'h6: return ns_to_cyc(GAP_6_NS);
      4'h7: return ns_to_cyc(GAP_7_NS);
      default: return ns_to_cyc(GAP_8_NS);
    endcase
  endfunction

  function automatic logic [RATIO_W-1:0] res_ratio(input logic [1:0] sel);
    case (sel)
      2'h0: return RATIO_W'(RES_0_UM / FINE_UM);
      2'h1: return RATIO_W'(RES_1_UM / FINE_UM);
      2'h2: return RATIO_W'(RES_2_UM / FINE_UM);
      default: return RATIO_W'(RES_3_UM / FINE_UM);
    endcase
  endfunction

  // forward order: lead moves first -> 00,10,11,01
  function automatic logic [1:0] quad_fwd(input logic [1:0] q);
    return {~q[0], q[1]};
  endfunction

  function automatic logic [1:0] quad_rev(input logic [1:0] q);
    return {q[0], ~q[1]};
  endfunction

endpackage

//--- qeo_gap_timer.sv
// spacing timer that holds off the next quadrature edge
`timescale 1ns/10ps
module qeo_gap_timer #(
  parameter int GW = 10
) (
  input wire logic ref_clk,          // 40 MHz clock
  input wire logic rst_n,            // synchronous reset
  input wire logic clk_en,           // freezes the count while low
  input wire logic start,            // an edge was emitted this cycle
  input wire logic [GW-1:0] cycles,  // least spacing in cycles
  output logic ready                 // next edge allowed
);

  logic [GW-1:0] cnt_ff;
  logic [GW-1:0] nxt_cnt;

  // age of the last edge, compared with the live spacing: a wider
  // spacing chosen after an edge still holds off the next one
  assign nxt_cnt = start ? GW'(1) :
                   (cnt_ff == '1) ? cnt_ff : cnt_ff + GW'(1);
  assign ready = (cnt_ff >= cycles);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_ff <= '1;
    end else if (clk_en) begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

//--- qeo_top.sv
// quadrature output stage: fine steps in, spaced A/B/index square waves out
//
// Notes on behaviour
// R1: lead and lag run a quarter period apart
// R2: forward lead moves first, reverse lag first
// R3: one channel edge per resolution step
// R4: resolution 5, 10, 25 or 50 um
// R5: complementary pairs or single-ended supply-level outputs
// R6: never two edges closer than chosen spacing
// R7: index at reference position, lamp shows it
// R8: same position gives same count, within one
// R9: controller counts faster than edge rate
// R10: controller counts four edges per period
// R11: no motion keeps channels steady
`timescale 1ns/10ps
module qeo_top (
  input wire logic ref_clk,                   // 40 MHz clock
  input wire logic rst_n,                     // synchronous reset
  input wire logic clk_en,                    // freezes all state while low
  input wire qeo_pkg::qeo_cfg_t cfg_pins,     // configuration straps (pins)
  input wire logic fine_step,                 // one 5 um step from interpolator
  input wire logic fine_fwd,                  // direction of that step
  input wire logic ref_mark,                  // reference position seen
  output logic quad_channel_lead_p,           // lead channel
  output logic quad_channel_lead_n,           // lead complement
  output logic quad_channel_lag_p,            // lag channel
  output logic quad_channel_lag_n,            // lag complement
  output logic index_pulse_p,                 // index
  output logic index_pulse_n,                 // index complement
  output logic compl_oe,                      // complements driven
  output logic ref_lamp,                      // reference indicator
  output logic overspeed                      // backlog saturated, count lost
);

  // ----------------------------------------------------------------
  // configuration straps
  // ----------------------------------------------------------------
  qeo_pkg::qeo_cfg_t cfg_s1_ff;
  qeo_pkg::qeo_cfg_t cfg_s2_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_s1_ff <= '0;
      cfg_s2_ff <= '0;
    end else if (clk_en) begin
      cfg_s1_ff <= cfg_pins;
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  wire logic [qeo_pkg::RATIO_W-1:0] ratio = qeo_pkg::res_ratio(cfg_s2_ff.res_sel); // see R4
  wire logic [qeo_pkg::GAP_W-1:0] gap_cyc = qeo_pkg::gap_cycles(cfg_s2_ff.gap_sel);

  // ----------------------------------------------------------------
  // fine position within one increment
  // ----------------------------------------------------------------
  // exact modulo tracking keeps the count repeatable on return
  logic [qeo_pkg::RATIO_W-1:0] fine_ff;
  logic [qeo_pkg::RATIO_W-1:0] nxt_fine;
  wire logic step_ok = clk_en & fine_step;
  wire logic wrap_fwd = step_ok & fine_fwd & (fine_ff >= ratio - qeo_pkg::RATIO_W'(1));
  wire logic wrap_rev = step_ok & ~fine_fwd & (fine_ff == '0);

  assign nxt_fine = wrap_fwd ? '0 :                                    // see R8
                    wrap_rev ? ratio - qeo_pkg::RATIO_W'(1) :
                    (step_ok & fine_fwd) ? fine_ff + qeo_pkg::RATIO_W'(1) :
                    step_ok ? fine_ff - qeo_pkg::RATIO_W'(1) : fine_ff;

  // ----------------------------------------------------------------
  // edge backlog and pacing
  // ----------------------------------------------------------------
  localparam int BW = qeo_pkg::BACKLOG_W;
  logic signed [BW-1:0] backlog_ff;
  logic [1:0] quad_ff;
  logic gap_ready;

  wire logic edge_pend = (backlog_ff != '0);
  wire logic edge_fwd = ~backlog_ff[BW-1];
  wire logic edge_go = clk_en & edge_pend & gap_ready;                 // see R6, R11
  wire logic [1:0] quad_step = edge_fwd ? qeo_pkg::quad_fwd(quad_ff) :  // see R1, R2
                                          qeo_pkg::quad_rev(quad_ff);
  wire logic [1:0] nxt_quad = edge_go ? quad_step : quad_ff;           // see R3

  wire logic signed [BW:0] delta = (wrap_fwd ? (BW+1)'(1) : '0)
                                 - (wrap_rev ? (BW+1)'(1) : '0)
                                 - ((edge_go & edge_fwd) ? (BW+1)'(1) : '0)
                                 + ((edge_go & ~edge_fwd) ? (BW+1)'(1) : '0);
  wire logic signed [BW:0] sum = {backlog_ff[BW-1], backlog_ff} + delta;
  // limitation: motion faster than the spacing allows fills the backlog
  wire logic sat = (sum[BW] != sum[BW-1]);
  wire logic signed [BW-1:0] nxt_backlog = sat ? backlog_ff : sum[BW-1:0];

  qeo_gap_timer #(
    .GW(qeo_pkg::GAP_W)
  ) u_gap (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .start(edge_go),
    .cycles(gap_cyc),
    .ready(gap_ready)
  );

  // ----------------------------------------------------------------
  // index
  // ----------------------------------------------------------------
  logic ref_arm_ff;
  logic idx_ff;
  wire logic arm_set = clk_en & ref_mark & cfg_s2_ff.ref_opt;
  wire logic idx_hit = edge_go & ref_arm_ff & (quad_step == qeo_pkg::QUAD_INDEX);
  // a new mark in the cycle the old one is used keeps the arm set
  wire logic nxt_arm = arm_set | (ref_arm_ff & ~idx_hit);
  wire logic nxt_idx = edge_go ? idx_hit : idx_ff;                     // see R7

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fine_ff <= '0;
      backlog_ff <= '0;
      quad_ff <= qeo_pkg::QUAD_RESET;
      ref_arm_ff <= 1'b0;
      idx_ff <= 1'b0;
    end else if (clk_en) begin
      fine_ff <= nxt_fine;
      backlog_ff <= nxt_backlog;
      quad_ff <= nxt_quad;
      ref_arm_ff <= nxt_arm;
      idx_ff <= nxt_idx;
    end
  end

  // ----------------------------------------------------------------
  // output drivers
  // ----------------------------------------------------------------
  // complements held low when single ended so unused wires stay quiet
  wire logic dm = cfg_s2_ff.diff_mode;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      quad_channel_lead_p <= 1'b0;
      quad_channel_lead_n <= 1'b0;
      quad_channel_lag_p <= 1'b0;
      quad_channel_lag_n <= 1'b0;
      index_pulse_p <= 1'b0;
      index_pulse_n <= 1'b0;
      compl_oe <= 1'b0;
      ref_lamp <= 1'b0;
      overspeed <= 1'b0;
    end else if (clk_en) begin
      quad_channel_lead_p <= nxt_quad[1];
      quad_channel_lag_p <= nxt_quad[0];
      quad_channel_lead_n <= dm & ~nxt_quad[1];                        // see R5
      quad_channel_lag_n <= dm & ~nxt_quad[0];                         // see R5
      index_pulse_p <= nxt_idx;
      index_pulse_n <= dm & ~nxt_idx;                                  // see R5
      compl_oe <= dm;
      ref_lamp <= nxt_idx;                                             // see R7
      overspeed <= sat | overspeed;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // edge age kept apart from the pacing timer, for the spacing check
  logic [qeo_pkg::GAP_W-1:0] since_ff;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      since_ff <= '1;
    end else if (clk_en) begin
      since_ff <= edge_go ? qeo_pkg::GAP_W'(1) :
                  (since_ff == '1) ? since_ff : since_ff + qeo_pkg::GAP_W'(1);
    end
  end

  wire logic [1:0] quad_out = {quad_channel_lead_p, quad_channel_lag_p};

  quad_single_a: assert property ($changed(quad_out) |-> $onehot(quad_out ^ $past(quad_out))) // see R1
    else $error("both channels moved together");
  // forward: lead moves from equal levels, lag from unequal ones
  fwd_order_a: assert property (edge_go && edge_fwd |=> (quad_out ^ $past(quad_out)) // see R2
      == (($past(quad_out[1]) == $past(quad_out[0])) ? 2'h2 : 2'h1))
    else $error("forward edge in wrong order");
  // reverse: the mirror image, lag moves from equal levels
  rev_order_a: assert property (edge_go && !edge_fwd |=> (quad_out ^ $past(quad_out)) // see R2
      == (($past(quad_out[1]) == $past(quad_out[0])) ? 2'h1 : 2'h2))
    else $error("reverse edge in wrong order");
  // an increment on an empty backlog reaches the pins two edges later
  edge_cause_a: assert property (wrap_fwd && backlog_ff == '0 && gap_ready ##1 clk_en // see R3
      |=> $changed(quad_out))
    else $error("increment did not reach the channels");
  min_gap_a: assert property (edge_go |-> since_ff >= gap_cyc) // see R6
    else $error("edges closer than minimum spacing");
  compl_pair_a: assert property (compl_oe |-> quad_channel_lead_n != quad_channel_lead_p
      && quad_channel_lag_n != quad_channel_lag_p && index_pulse_n != index_pulse_p) // see R5
    else $error("complement mismatch");
  single_end_a: assert property (!compl_oe |-> !quad_channel_lead_n && !quad_channel_lag_n
      && !index_pulse_n) // see R5
    else $error("complement driven in single ended mode");
  index_pos_a: assert property ($rose(index_pulse_p) |-> quad_out == qeo_pkg::QUAD_INDEX
      && ref_lamp) // see R7
    else $error("index off reference quarter or lamp dark");
  hold_still_a: assert property (clk_en && !edge_go |=> $stable(quad_out)) // see R11
    else $error("channel moved without motion");
  step_track_a: assert property (wrap_fwd && !edge_go && !sat |=> backlog_ff == $past(backlog_ff) + 1) // see R8
    else $error("increment lost");
  lamp_follow_a: assert property (ref_lamp == index_pulse_p) // see R7
    else $error("lamp differs from index");
  spd_flag_a: assert property (clk_en && sat |=> overspeed) // see R8
    else $error("lost increment not flagged");

  // main scenarios
  fwd_edge_c: cover property (edge_go && edge_fwd ##[1:1000] edge_go);
  rev_edge_c: cover property (edge_go && !edge_fwd);
  index_c: cover property ($rose(index_pulse_p));
  pair_mode_c: cover property ($rose(compl_oe));
  gap_hold_c: cover property (edge_pend && !gap_ready);

endmodule

//--- qeo_ctrl_model.sv
// counting controller model that decodes the quadrature channels
`timescale 1ns/10ps
module qeo_ctrl_model (
  input wire logic ref_clk,                // counts every cycle, far above edge rate
  input wire logic rst_n,                  // synchronous reset
  input wire logic gap_clr,                // restart the least spacing record
  input wire logic lead,                   // lead channel
  input wire logic lag,                    // lag channel
  output logic signed [15:0] count_ff,     // 4-fold position count
  output logic jump_ff,                    // both channels moved at once
  output int gap_min_ff                    // least cycles between edges
);
  logic [1:0] prev_ff;
  int gap_cnt_ff;
  wire logic [1:0] cur = {lead, lag};
  wire logic moved = (cur != prev_ff);
  // forward goes 00,10,11,01: lead first
  wire logic up = (cur == {~prev_ff[0], prev_ff[1]});
  wire logic down = (cur == {prev_ff[0], ~prev_ff[1]});

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prev_ff <= 2'h0;
      count_ff <= '0;
      jump_ff <= 1'b0;
      gap_cnt_ff <= 0;
      gap_min_ff <= 100000;
    end else begin
      prev_ff <= cur;
      gap_cnt_ff <= moved ? 1 : gap_cnt_ff + 1;
      if (gap_clr) begin
        gap_min_ff <= 100000;
      end else if (moved && gap_cnt_ff < gap_min_ff) begin
        gap_min_ff <= gap_cnt_ff;
      end
      // every single-channel edge counts once; a move of both at once only sets jump_ff
      if (moved && up) begin
        count_ff <= count_ff + 16'sd1;
      end else if (moved && down) begin
        count_ff <= count_ff - 16'sd1;
      end else if (moved) begin
        jump_ff <= 1'b1;
      end
    end
  end
endmodule

//--- test_qeo_top.sv
// self-checking bench of the quadrature output stage
`timescale 1ns/10ps
module test_qeo_top;
  logic ref_clk, rst_n, clk_en, fine_step, fine_fwd, ref_mark, gap_clr;
  qeo_pkg::qeo_cfg_t cfg_pins;
  logic lead_p, lead_n, lag_p, lag_n, idx_p, idx_n, compl_oe, ref_lamp, overspeed, jump;
  logic signed [15:0] count, c0;
  logic [1:0] lv;
  int gap_min, mismatches, num_checks, r, k;
  int ratio[4] = '{1, 2, 5, 10};

  qeo_top qeo_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cfg_pins(cfg_pins),
    .fine_step(fine_step), .fine_fwd(fine_fwd), .ref_mark(ref_mark),
    .quad_channel_lead_p(lead_p), .quad_channel_lead_n(lead_n), .quad_channel_lag_p(lag_p),
    .quad_channel_lag_n(lag_n), .index_pulse_p(idx_p), .index_pulse_n(idx_n),
    .compl_oe(compl_oe), .ref_lamp(ref_lamp), .overspeed(overspeed));
  qeo_ctrl_model qeo_ctrl_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .gap_clr(gap_clr),
    .lead(lead_p), .lag(lag_p), .count_ff(count), .jump_ff(jump), .gap_min_ff(gap_min));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  // straps pass two flops and the output register, so give them four edges
  task automatic set_cfg(input logic o, input logic d, input logic [1:0] rs, input logic [3:0] g);
    cfg_pins <= '{o, d, rs, g};
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic steps(input logic fwd, input int n);
    repeat (n) begin
      fine_step <= 1'b1;
      fine_fwd <= fwd;
      @(posedge ref_clk);
    end
    fine_step <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_count(input logic signed [15:0] e);
    for (int i = 0; i < 2000 && count !== e; i++) @(posedge ref_clk);
    check(count === e, "position count wrong");
    if (count !== e) finish_test();
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_res();
    for (r = 0; r < 4; r++) begin
      set_cfg(1'b0, 1'b0, r[1:0], 4'h0);
      c0 = count;
      steps(1'b1, 20);
      wait_count(c0 + 16'(20 / ratio[r]));
      steps(1'b0, 20);
      wait_count(c0);
    end
    check(jump === 1'b0, "both channels moved together");
  endtask

  task automatic t_gap();
    set_cfg(1'b0, 1'b0, 2'h0, 4'h2);
    gap_clr <= 1'b1;
    @(posedge ref_clk);
    gap_clr <= 1'b0;
    c0 = count;
    steps(1'b1, 40);
    wait_count(c0 + 16'sd40);
    check(gap_min >= 20, "edges closer than spacing");
    steps(1'b0, 40);
    wait_count(c0);
  endtask

  task automatic t_idle();
    c0 = count;
    lv = {lead_p, lag_p};
    clk_en <= 1'b0;
    steps(1'b1, 10);
    clk_en <= 1'b1;
    repeat (50) @(posedge ref_clk);
    check(count === c0 && {lead_p, lag_p} === lv, "moved while idle");
  endtask

  task automatic t_diff();
    set_cfg(1'b0, 1'b1, 2'h0, 4'h0);
    c0 = count;
    steps(1'b1, 1);
    wait_count(c0 + 16'sd1);
    check(lead_n === ~lead_p && lag_n === ~lag_p && idx_n === ~idx_p, "pair");
    check(compl_oe === 1'b1, "complements not enabled");
    set_cfg(1'b0, 1'b0, 2'h0, 4'h0);
    check(compl_oe === 1'b0 && lead_n === 1'b0 && lag_n === 1'b0 && idx_n === 1'b0,
      "single ended");
  endtask

  // index rises with the edge that reaches lead=lag=1 and drops at the next
  task automatic t_index();
    set_cfg(1'b1, 1'b0, 2'h0, 4'h0);
    ref_mark <= 1'b1;
    @(posedge ref_clk);
    ref_mark <= 1'b0;
    for (k = 0; k < 4 && !(lead_p === 1'b1 && lag_p === 1'b1); k++) begin
      c0 = count;
      steps(1'b1, 1);
      wait_count(c0 + 16'sd1);
    end
    check(idx_p === 1'b1 && ref_lamp === 1'b1, "index missing");
    c0 = count;
    steps(1'b1, 1);
    wait_count(c0 + 16'sd1);
    check(idx_p === 1'b0 && ref_lamp === 1'b0, "index too long");
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    fine_step = 1'b0;
    fine_fwd = 1'b1;
    ref_mark = 1'b0;
    gap_clr = 1'b0;
    cfg_pins = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_res();
    t_gap();
    t_idle();
    t_diff();
    t_index();
    check(overspeed === 1'b0, "count lost");
    finish_test();
  end
endmodule
